//--- hdl/tirq_top.sv
// Functional notes
// - Writing 1 to bit 0 of 0x18 resets registers, reloads settings, resets bus.
// - Soft reset command bit clears itself after the reset it triggered.
// - Bit 7 of 0x19 latches when power-ok output goes active to inactive.
// - Bit 6 is read-only linear-regulator summary, clear when its register is zero.
// - Bit 5 is read-only buck summary, clear when buck register is zero.
// - Bit 4 latches when external sync clock appears or disappears.
// - Overheat shutdown latches bit 3, disables regulators, drives general outputs low.
// - While overheat shutdown flag is set, regulator enables are refused.
// - Bit 2 latches on overheat warning; the live warning state is not reported.
// - Input overvoltage latches bit 1, disables regulators, drives outputs low.
// - Bit 0 latches when a new load current result is stored.
// - Latched bits 7 and 4..0 stay set until host writes 1 there.
// - Bit 0 of 0x1A latches on supply undervoltage or soft reset command.
// - Undervoltage or soft reset disables regulators, defaults registers, restarts.
// - Reserved bits 7..1 of 0x18 and 0x1A read zero, host leaves them.
// - Buck and linear-regulator source bits 6..4 and 2..0 latch and clear by writing 1.
`timescale 1ns/1ps
`default_nettype none
module tirq_top #(
   parameter int NUM_REGULATORS = 4,
   parameter int RESET_CYCLES = tirq_pkg::SOFT_RESET_CYCLES
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire tirq_pkg::tirq_reg_req_t reg_req,
   output logic [7:0] reg_rdata,
   input wire tirq_pkg::tirq_events_t events_in,
   input wire logic [7:0] buck_event_set,
   input wire logic [7:0] linreg_event_set,
   input wire logic [NUM_REGULATORS-1:0] regulator_enable_req,
   input wire logic general_output_a_req,
   input wire logic general_output_b_req,
   output logic [NUM_REGULATORS-1:0] regulator_enable,
   output logic general_output_a,
   output logic general_output_b,
   output logic [7:0] buck_event_reg,
   output logic [7:0] linreg_event_reg,
   output logic settings_reload,
   output logic bus_if_reset,
   output logic startup_restart
);
   import tirq_pkg::*;

   typedef struct packed {
      tirq_events_t sync1;
      tirq_events_t sync2;
      tirq_events_t prev;
      logic [2:0] fill;
      tirq_state_t fsm;
      logic [3:0] rst_count;
      logic soft_reset_cmd;
      logic power_ok_lost_flag;
      logic sync_clk_change_flag;
      logic overheat_shutdown_flag;
      logic overheat_warning_flag;
      logic input_overvoltage_flag;
      logic current_meas_done_flag;
      logic reset_event_flag;
      logic uv_pending;
      logic [7:0] rdata;
      logic [NUM_REGULATORS-1:0] reg_en;
      logic gpo_a;
      logic gpo_b;
   } tirq_state_s_t;

   tirq_state_s_t state;
   tirq_state_s_t next_state;
   logic internal_rst_n;
   logic buck_pending;
   logic linreg_pending;

   function automatic logic latch_bit(input logic cur, input logic ev, input logic clr);
      latch_bit = ev | (cur & ~clr);
   endfunction

   function automatic logic wr_hit(input tirq_reg_req_t rq, input logic [7:0] a);
      wr_hit = rq.wr_en && (rq.addr == a);
   endfunction

   assign internal_rst_n = rst_n && (state.fsm != TIRQ_SOFT_RESET);

   tirq_source_flags #(.WIDTH(8), .USED_MASK(SOURCE_EVENT_MASK)) u_buck_flags (
      .clock(clock),
      .rst_n(internal_rst_n),
      .set_pulse(buck_event_set),
      .clear_wr(wr_hit(reg_req, ADDR_BUCK_EVENT_FLAGS)),
      .clear_data(reg_req.wdata),
      .flags(buck_event_reg),
      .pending(buck_pending)
   );

   tirq_source_flags #(.WIDTH(8), .USED_MASK(SOURCE_EVENT_MASK)) u_linreg_flags (
      .clock(clock),
      .rst_n(internal_rst_n),
      .set_pulse(linreg_event_set),
      .clear_wr(wr_hit(reg_req, ADDR_LINREG_EVENT_FLAGS)),
      .clear_data(reg_req.wdata),
      .flags(linreg_event_reg),
      .pending(linreg_pending)
   );

   always_comb begin
      logic pg_fall;
      logic clk_change;
      logic sd_rise;
      logic warn_rise;
      logic ovp_rise;
      logic meas_rise;
      logic uv_rise;
      logic wr_top;
      logic wr_rst_evt;
      logic [7:0] wd;
      logic fault;
      pg_fall = 1'b0;
      clk_change = 1'b0;
      sd_rise = 1'b0;
      warn_rise = 1'b0;
      ovp_rise = 1'b0;
      meas_rise = 1'b0;
      uv_rise = 1'b0;
      wr_top = 1'b0;
      wr_rst_evt = 1'b0;
      wd = reg_req.wdata;
      fault = 1'b0;
      next_state = state;
      next_state.sync1 = events_in;
      next_state.sync2 = state.sync1;
      next_state.prev = state.sync2;
      pg_fall = state.prev.power_ok_output && !state.sync2.power_ok_output;
      // Sync chain loaded flag: a clock already present at power-up is no change
      next_state.fill = {state.fill[1:0], 1'b1};
      clk_change = state.fill[2]
         && (state.prev.sync_clk_detected != state.sync2.sync_clk_detected);
      sd_rise = state.sync2.overheat_shutdown_live && !state.prev.overheat_shutdown_live;
      warn_rise = state.sync2.overheat_warning_live && !state.prev.overheat_warning_live;
      ovp_rise = state.sync2.overvoltage_live && !state.prev.overvoltage_live;
      meas_rise = state.sync2.current_meas_done && !state.prev.current_meas_done;
      uv_rise = state.sync2.analog_supply_low && !state.prev.analog_supply_low;
      wr_top = wr_hit(reg_req, ADDR_TOP_EVENT_FLAGS);
      wr_rst_evt = wr_hit(reg_req, ADDR_RESET_EVENT_FLAGS);
      next_state.power_ok_lost_flag = latch_bit(state.power_ok_lost_flag, pg_fall,
         wr_top && wd[BIT_POWER_OK_LOST]);
      next_state.sync_clk_change_flag = latch_bit(state.sync_clk_change_flag, clk_change,
         wr_top && wd[BIT_SYNC_CLK_CHANGE]);
      next_state.overheat_shutdown_flag = latch_bit(state.overheat_shutdown_flag, sd_rise,
         wr_top && wd[BIT_OVERHEAT_SHUTDOWN]);
      next_state.overheat_warning_flag = latch_bit(state.overheat_warning_flag, warn_rise,
         wr_top && wd[BIT_OVERHEAT_WARNING]);
      next_state.input_overvoltage_flag = latch_bit(state.input_overvoltage_flag, ovp_rise,
         wr_top && wd[BIT_INPUT_OVERVOLTAGE]);
      next_state.current_meas_done_flag = latch_bit(state.current_meas_done_flag, meas_rise,
         wr_top && wd[BIT_CURRENT_MEAS_DONE]);
      next_state.reset_event_flag = latch_bit(state.reset_event_flag, 1'b0,
         wr_rst_evt && wd[BIT_RESET_EVENT]);
      // Undervoltage seen while running restarts the block like a soft reset
      next_state.uv_pending = state.uv_pending | uv_rise;
      // live faults force outputs off at once, not only on the latch
      // Overvoltage forces only while live; its latch alone does not block enables
      fault = state.overheat_shutdown_flag
         || state.sync2.overheat_shutdown_live || state.sync2.overvoltage_live;
      if (fault || state.overheat_shutdown_flag) begin
         next_state.reg_en = '0;
      end else begin
         next_state.reg_en = regulator_enable_req;
      end
      next_state.gpo_a = fault ? 1'b0 : general_output_a_req;
      next_state.gpo_b = fault ? 1'b0 : general_output_b_req;
      case (reg_req.addr)
         ADDR_SOFT_RESET_CONTROL: next_state.rdata = {7'h00, state.soft_reset_cmd};
         ADDR_TOP_EVENT_FLAGS: begin
            next_state.rdata = {state.power_ok_lost_flag,
               linreg_pending,
               buck_pending,
               state.sync_clk_change_flag, state.overheat_shutdown_flag,
               state.overheat_warning_flag, state.input_overvoltage_flag,
               state.current_meas_done_flag};
         end
         ADDR_RESET_EVENT_FLAGS: next_state.rdata = {7'h00, state.reset_event_flag};
         ADDR_BUCK_EVENT_FLAGS: next_state.rdata = buck_event_reg;
         ADDR_LINREG_EVENT_FLAGS: next_state.rdata = linreg_event_reg;
         default: next_state.rdata = RESET_VALUE_REG;
      endcase
      if (!reg_req.rd_en) begin
         next_state.rdata = state.rdata;
      end
      case (state.fsm)
         TIRQ_RUN: begin
            if ((wr_hit(reg_req, ADDR_SOFT_RESET_CONTROL) && wd[BIT_SOFT_RESET_CMD])
                  || state.uv_pending) begin
               next_state.soft_reset_cmd = 1'b1;
               next_state.fsm = TIRQ_SOFT_RESET;
               next_state.rst_count = 4'(RESET_CYCLES - 1);
            end
         end
         TIRQ_SOFT_RESET: begin
            next_state = '0;
            next_state.sync1 = events_in;
            next_state.sync2 = state.sync1;
            next_state.prev = state.sync2;
            next_state.fill = state.fill;
            next_state.fsm = TIRQ_SOFT_RESET;
            next_state.soft_reset_cmd = 1'b1;
            next_state.rst_count = state.rst_count - 4'h1;
            if (state.rst_count == 4'h0) begin
               next_state.soft_reset_cmd = 1'b0;
               next_state.fsm = TIRQ_RUN;
               next_state.reset_event_flag = 1'b1;
            end
         end
         default: next_state.fsm = TIRQ_RUN;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state <= '0;
         state.fsm <= TIRQ_RUN;
         // Power-up itself counts as an undervoltage reset event
         state.reset_event_flag <= 1'b1;
      end else begin
         state <= next_state;
      end
   end

   assign reg_rdata = state.rdata;
   assign regulator_enable = state.reg_en;
   assign general_output_a = state.gpo_a;
   assign general_output_b = state.gpo_b;
   assign settings_reload = (state.fsm == TIRQ_SOFT_RESET);
   assign bus_if_reset = (state.fsm == TIRQ_SOFT_RESET);
   assign startup_restart = (state.fsm == TIRQ_SOFT_RESET) && (state.rst_count == 4'h0);
endmodule
`default_nettype wire

//--- hdl/tirq_pkg.sv
package tirq_pkg;
   localparam logic [7:0] ADDR_SOFT_RESET_CONTROL = 8'h18;
   localparam logic [7:0] ADDR_TOP_EVENT_FLAGS = 8'h19;
   localparam logic [7:0] ADDR_RESET_EVENT_FLAGS = 8'h1A;
   localparam logic [7:0] ADDR_BUCK_EVENT_FLAGS = 8'h1B;
   localparam logic [7:0] ADDR_LINREG_EVENT_FLAGS = 8'h1C;
   localparam int BIT_SOFT_RESET_CMD = 0;
   localparam int BIT_POWER_OK_LOST = 7;
   localparam int BIT_LINREG_SUMMARY = 6;
   localparam int BIT_BUCK_SUMMARY = 5;
   localparam int BIT_SYNC_CLK_CHANGE = 4;
   localparam int BIT_OVERHEAT_SHUTDOWN = 3;
   localparam int BIT_OVERHEAT_WARNING = 2;
   localparam int BIT_INPUT_OVERVOLTAGE = 1;
   localparam int BIT_CURRENT_MEAS_DONE = 0;
   localparam int BIT_RESET_EVENT = 0;
   localparam logic [7:0] RESET_VALUE_REG = 8'h00;
   localparam logic [7:0] TOP_LATCHED_MASK = 8'h9F;
   localparam logic [7:0] SOURCE_EVENT_MASK = 8'h77;
   localparam logic [7:0] RESET_EVENT_MASK = 8'h01;
   // Cycles the internal reset pulse lasts after a soft reset command
   localparam int SOFT_RESET_CYCLES = 4;

   typedef struct packed {
      logic wr_en;
      logic rd_en;
      logic [7:0] addr;
      logic [7:0] wdata;
   } tirq_reg_req_t;

   typedef struct packed {
      logic power_ok_output;
      logic sync_clk_detected;
      logic overheat_shutdown_live;
      logic overheat_warning_live;
      logic overvoltage_live;
      logic current_meas_done;
      logic analog_supply_low;
   } tirq_events_t;

   typedef enum logic [1:0] {
      TIRQ_RUN = 2'b01,
      TIRQ_SOFT_RESET = 2'b10
   } tirq_state_t;
endpackage

//--- hdl/tirq_source_flags.sv
`timescale 1ns/1ps
`default_nettype none
// Bank of write-one-to-clear source flags; a summary bit shows any pending
module tirq_source_flags #(
   parameter int WIDTH = 8,
   parameter logic [WIDTH-1:0] USED_MASK = '1
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] set_pulse,
   input wire logic clear_wr,
   input wire logic [WIDTH-1:0] clear_data,
   output logic [WIDTH-1:0] flags,
   output logic pending
);
   typedef struct packed {
      logic [WIDTH-1:0] flags;
   } tirq_src_state_t;
   tirq_src_state_t state;
   tirq_src_state_t next_state;

   always_comb begin
      next_state = state;
      for (int i = 0; i < WIDTH; i++) begin
         if (clear_wr && clear_data[i]) begin
            next_state.flags[i] = 1'b0;
         end
         if (set_pulse[i] && USED_MASK[i]) begin
            next_state.flags[i] = 1'b1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign flags = state.flags;
   assign pending = |state.flags;
endmodule
`default_nettype wire

//--- verification/tirq_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
module tirq_top_properties
   import tirq_pkg::*;
#(
   parameter int NUM_REGULATORS = 4,
   parameter int RESET_CYCLES = 4
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire tirq_pkg::tirq_reg_req_t reg_req,
   input wire logic [7:0] reg_rdata,
   input wire tirq_pkg::tirq_events_t events_in,
   input wire logic [7:0] buck_event_set,
   input wire logic [NUM_REGULATORS-1:0] regulator_enable,
   input wire logic general_output_a,
   input wire logic general_output_b,
   input wire logic [7:0] buck_event_reg,
   input wire logic [7:0] linreg_event_reg,
   input wire logic settings_reload,
   input wire logic bus_if_reset,
   input wire logic startup_restart
);
   localparam int RLO = RESET_CYCLES - 1;
   localparam int RHI = RESET_CYCLES;
   logic [7:0] buck_seen;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   always_ff @(posedge clock) begin
      buck_seen <= buck_event_set & SOURCE_EVENT_MASK;
   end
   a_soft_start: assert property (reg_req.wr_en && reg_req.addr == ADDR_SOFT_RESET_CONTROL
      && reg_req.wdata[0] && !settings_reload |=> settings_reload && bus_if_reset)
      else $error("soft reset did not start");
   a_reset_length: assert property ($rose(settings_reload)
      |-> ##[RLO:RHI] startup_restart ##1 !settings_reload) else $error("bad reset length");
   a_restart_inside: assert property (startup_restart |-> settings_reload && bus_if_reset)
      else $error("restart outside reset");
   a_reset_no_regs: assert property (settings_reload && $past(settings_reload)
      |-> regulator_enable == '0) else $error("regulator on during reset");
   a_shutdown_forces: assert property (events_in.overheat_shutdown_live [*6]
      |-> regulator_enable == '0 && !general_output_a && !general_output_b)
      else $error("shutdown did not force outputs");
   a_ovp_forces: assert property (events_in.overvoltage_live [*6]
      |-> regulator_enable == '0 && !general_output_a && !general_output_b)
      else $error("overvoltage did not force outputs");
   a_cmd_self_clear: assert property (reg_req.rd_en && !settings_reload
      && reg_req.addr == ADDR_SOFT_RESET_CONTROL |=> reg_rdata == RESET_VALUE_REG)
      else $error("reset command reads nonzero");
   a_event_reserved: assert property (reg_req.rd_en && !settings_reload
      && reg_req.addr == ADDR_RESET_EVENT_FLAGS |=> reg_rdata[7:1] == 7'h00)
      else $error("reserved bits nonzero");
   a_summary_or: assert property (reg_req.rd_en && !settings_reload
      && reg_req.addr == ADDR_TOP_EVENT_FLAGS
      |=> reg_rdata[6:5] == {|$past(linreg_event_reg), |$past(buck_event_reg)})
      else $error("summary bits wrong");
   a_buck_latch: assert property ((buck_event_set & SOURCE_EVENT_MASK) != 8'h00
      && !settings_reload |=> (buck_event_reg & buck_seen) == buck_seen)
      else $error("buck flag not latched");
   c_reset: cover property ($rose(settings_reload));
   c_buck: cover property (buck_event_reg != 8'h00);
   c_shut: cover property (events_in.overheat_shutdown_live [*6]);
endmodule
`default_nettype wire

//--- verification/tirq_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module tirq_host_model
   import tirq_pkg::*;
(
   input wire logic clock,
   output tirq_pkg::tirq_reg_req_t reg_req
);
   initial reg_req = '0;
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      reg_req <= '{wr_en: w, rd_en: !w, addr: a, wdata: d};
      @(negedge clock);
      // Idle bus shows inverted values so stale data cannot pass
      reg_req <= '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: ~d};
   endtask
endmodule
`default_nettype wire

//--- verification/tirq_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tirq_top_tb;
   import tirq_pkg::*;
   localparam int RST = 4;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   tirq_reg_req_t reg_req;
   logic [6:0] ev = '0;
   tirq_events_t events_in;
   logic [7:0] reg_rdata, buck_event_reg, linreg_event_reg, v;
   logic [7:0] buck_event_set = '0, linreg_event_set = '0;
   logic [3:0] regulator_enable_req = '0, regulator_enable, req;
   logic general_output_a_req = 1'b0, general_output_b_req = 1'b0;
   logic general_output_a, general_output_b, settings_reload, bus_if_reset, startup_restart;
   logic [7:0] exp_q[$];
   logic seen = 1'b0;
   int bad_count = 0, n_tests = 0;
   int pos[6] = '{6, 5, 4, 3, 2, 1};
   logic [7:0] msk[6] = '{8'h80, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01};
   assign events_in = ev;
   always #12.5 clock = ~clock;
   tirq_host_model i_host (.clock, .reg_req);
   tirq_top #(.NUM_REGULATORS(4), .RESET_CYCLES(RST)) i_dut (.clock, .rst_n, .reg_req,
      .reg_rdata, .events_in, .buck_event_set, .linreg_event_set, .regulator_enable_req,
      .general_output_a_req, .general_output_b_req, .regulator_enable, .general_output_a,
      .general_output_b, .buck_event_reg, .linreg_event_reg, .settings_reload, .bus_if_reset,
      .startup_restart);
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      n_tests++;
      if (s !== e) begin
         bad_count++;
         $display("BAD %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_host.xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      i_host.xfer(1'b0, a, 8'h00);
   endtask
   always @(posedge clock) seen <= reg_req.rd_en;
   always @(negedge clock) begin
      if (seen && exp_q.size() > 0) begin
         chk(reg_rdata, exp_q.pop_front());
      end
   end
   initial begin
      idle(4000);
      bad_count++;
      end_of_test();
   end
   initial begin
      void'($urandom(71858));
      req = 4'($urandom_range(15, 1));
      idle(6);
      rst_n = 1'b1;
      regulator_enable_req = req;
      general_output_a_req = 1'b1;
      general_output_b_req = 1'b1;
      rd(8'h00, 8'h00);
      rd(ADDR_SOFT_RESET_CONTROL, 8'h00);
      rd(ADDR_TOP_EVENT_FLAGS, 8'h00);
      rd(ADDR_RESET_EVENT_FLAGS, 8'h01);
      wr(ADDR_RESET_EVENT_FLAGS, 8'h01);
      rd(ADDR_RESET_EVENT_FLAGS, 8'h00);
      wr(ADDR_SOFT_RESET_CONTROL, 8'h00);
      rd(ADDR_SOFT_RESET_CONTROL, 8'h00);
      for (int i = 0; i < 6; i++) begin
         ev[pos[i]] = 1'b1;
         idle(6);
         if (pos[i] == 4 || pos[i] == 2) begin
            chk(8'({regulator_enable, general_output_a, general_output_b}), 8'h00);
         end
         ev[pos[i]] = 1'b0;
         idle(6);
         rd(ADDR_TOP_EVENT_FLAGS, msk[i]);
         chk(8'(regulator_enable), pos[i] == 4 ? 8'h00 : 8'(req));
         wr(ADDR_TOP_EVENT_FLAGS, 8'h00);
         rd(ADDR_TOP_EVENT_FLAGS, msk[i]);
         wr(ADDR_TOP_EVENT_FLAGS, msk[i]);
         rd(ADDR_TOP_EVENT_FLAGS, 8'h00);
         chk(8'({regulator_enable, general_output_a}), 8'({req, 1'b1}));
      end
      for (int k = 0; k < 2; k++) begin
         v = (8'($urandom) & SOURCE_EVENT_MASK) | 8'h01;
         if (k == 0) buck_event_set = v;
         else linreg_event_set = v;
         idle(1);
         buck_event_set = '0;
         linreg_event_set = '0;
         idle(2);
         chk(k == 1 ? linreg_event_reg : buck_event_reg, v);
         rd(ADDR_TOP_EVENT_FLAGS, k == 1 ? 8'h40 : 8'h20);
         wr(k == 1 ? ADDR_LINREG_EVENT_FLAGS : ADDR_BUCK_EVENT_FLAGS, v);
         rd(ADDR_TOP_EVENT_FLAGS, 8'h00);
         chk(k == 1 ? linreg_event_reg : buck_event_reg, 8'h00);
      end
      buck_event_set = 8'h04;
      idle(1);
      buck_event_set = '0;
      wr(ADDR_SOFT_RESET_CONTROL, 8'h01);
      chk(8'({settings_reload, bus_if_reset}), 8'h03);
      idle(RST + 2);
      rd(ADDR_SOFT_RESET_CONTROL, 8'h00);
      rd(ADDR_RESET_EVENT_FLAGS, 8'h01);
      chk(buck_event_reg, 8'h00);
      wr(ADDR_RESET_EVENT_FLAGS, 8'h01);
      ev[0] = 1'b1;
      idle(8);
      ev[0] = 1'b0;
      idle(RST + 2);
      rd(ADDR_RESET_EVENT_FLAGS, 8'h01);
      idle(2);
      end_of_test();
   end
endmodule
bind tirq_top tirq_top_properties #(.NUM_REGULATORS(NUM_REGULATORS),
   .RESET_CYCLES(RESET_CYCLES)) i_props (.clock, .rst_n, .reg_req, .reg_rdata, .events_in,
   .buck_event_set, .regulator_enable, .general_output_a, .general_output_b, .buck_event_reg,
   .linreg_event_reg, .settings_reload, .bus_if_reset, .startup_restart);
`default_nettype wire
